// ---- common/ptw_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ptw_mem_if;
   logic req;
   logic [31:0] addr;
   logic ack;
   logic [31:0] rdata;
   modport walker (output req, output addr, input ack, input rdata);
   modport port (input req, input addr, output ack, output rdata);
endinterface
`default_nettype wire

// ---- common/ptw_pkg.sv ----
package ptw_pkg;
   // first-level and second-level descriptor type codes
   localparam logic [1:0] L1_FAULT = 2'h0;
   localparam logic [1:0] L1_COARSE = 2'h1;
   localparam logic [1:0] L1_SECTION = 2'h2;
   localparam logic [1:0] L1_FINE = 2'h3;
   localparam logic [1:0] L2_FAULT = 2'h0;
   localparam logic [1:0] L2_LARGE = 2'h1;
   localparam logic [1:0] L2_SMALL = 2'h2;
   localparam logic [1:0] L2_TINY = 2'h3;
   // page sizes reported on o_page_size
   localparam logic [2:0] SZ_NONE = 3'h0;
   localparam logic [2:0] SZ_SECTION = 3'h1;
   localparam logic [2:0] SZ_LARGE = 3'h2;
   localparam logic [2:0] SZ_SMALL = 3'h3;
   localparam logic [2:0] SZ_TINY = 3'h4;
   // fault codes reported on o_fault_code
   localparam logic [3:0] FLT_NONE = 4'h0;
   localparam logic [3:0] FLT_SECTION_XLT = 4'h5;
   localparam logic [3:0] FLT_PAGE_XLT = 4'h7;
   // register offsets on the apb slave
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_TABLE_BASE = 12'h004;
   localparam logic [11:0] OFS_MVA = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_PHYS = 12'h010;
   localparam logic [11:0] OFS_ATTR = 12'h014;
   localparam logic [11:0] OFS_L1_DESC = 12'h018;
   localparam logic [11:0] OFS_L2_DESC = 12'h01C;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_L1_REQ = 3'b001,
      ST_L1_WAIT = 3'b010,
      ST_L2_REQ = 3'b011,
      ST_L2_WAIT = 3'b100,
      ST_DONE = 3'b101
   } ptw_state_t;
endpackage

// ---- rtl/ptw_l2_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
// combinational decode of a second-level descriptor
module ptw_l2_decode
   import ptw_pkg::*;
(
   input wire logic [31:0] i_desc,
   input wire logic i_from_fine,
   input wire logic [31:0] i_mva,
   output logic o_fault,
   output logic [2:0] o_size,
   output logic [31:0] o_phys,
   output logic [7:0] o_perm
);
   wire [1:0] kind = i_desc[1:0];
   // a coarse table never yields a tiny page; type 11 there is read as small
   wire is_large = (kind == L2_LARGE);
   wire is_small = (kind == L2_SMALL) | ((kind == L2_TINY) & ~i_from_fine);
   wire is_tiny = (kind == L2_TINY) & i_from_fine;
   assign o_fault = (kind == L2_FAULT);
   assign o_size = is_large ? SZ_LARGE : is_small ? SZ_SMALL : is_tiny ? SZ_TINY : SZ_NONE;
   assign o_phys = is_large ? {i_desc[31:16], i_mva[15:0]} :
                   is_small ? {i_desc[31:12], i_mva[11:0]} :
                   is_tiny ? {i_desc[31:10], i_mva[9:0]} : 32'h0000_0000;
   // tiny pages: one permission field replicated into all four slots
   assign o_perm = is_tiny ? {4{i_desc[5:4]}} : i_desc[11:4];
endmodule
`default_nettype wire

// ---- rtl/ptw_mem_port.sv ----
`timescale 1ns/10ps
`default_nettype none
// registers the memory answer so the walker sees descriptors from a flip-flop
module ptw_mem_port (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   ptw_mem_if.port mif,
   output logic o_mem_req,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata
);
   logic ack_q;
   logic [31:0] rdata_q;
   assign o_mem_req = mif.req;
   assign o_mem_addr = mif.addr;
   assign mif.ack = ack_q;
   assign mif.rdata = rdata_q;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= i_mem_ack & mif.req & ~ack_q;
         if (i_mem_ack) begin
            rdata_q <= i_mem_rdata;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ptw_walker.sv ----
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ptw_walker
   import ptw_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_walk_start,
   input wire logic [31:0] i_modified_virtual_address,
   output logic o_walk_busy,
   output logic o_walk_done,
   output logic o_walk_fault,
   output logic [3:0] o_fault_code,
   output logic [31:0] o_phys_addr,
   output logic [2:0] o_page_size,
   output logic [7:0] o_access_permission_field,
   output logic [3:0] o_domain,
   output logic o_cachable,
   output logic o_bufferable,
   output logic o_mem_req,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata
);
   ptw_mem_if mif();
   ptw_state_t state;
   ptw_state_t next_state;
   logic [31:0] table_base_register;
   logic [31:0] modified_virtual_address;
   logic [31:0] l1_desc;
   logic [31:0] l2_desc;
   logic [31:0] phys;
   logic [2:0] size;
   logic [7:0] perm;
   logic [3:0] domain;
   logic [1:0] cb;
   logic [3:0] fault_code;
   logic done_pulse;

   ptw_mem_port u_port (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .mif(mif),
      .o_mem_req(o_mem_req),
      .o_mem_addr(o_mem_addr),
      .i_mem_ack(i_mem_ack),
      .i_mem_rdata(i_mem_rdata)
   );

   function automatic logic [31:0] l2_addr(input logic [31:0] desc, input logic [31:0] va);
      if (desc[1:0] == L1_FINE) begin
         l2_addr = {desc[31:12], va[19:10], 2'b00};
      end else begin
         l2_addr = {desc[31:10], va[19:12], 2'b00};
      end
   endfunction

   // apb decode
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd_sel = psel & ~pwrite;
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_base = (paddr == OFS_TABLE_BASE);
   wire hit_mva = (paddr == OFS_MVA);
   wire hit_any = hit_ctrl | hit_base | hit_mva | (paddr == OFS_STATUS) |
                  (paddr == OFS_PHYS) | (paddr == OFS_ATTR) |
                  (paddr == OFS_L1_DESC) | (paddr == OFS_L2_DESC);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   wire sw_go = apb_wr & hit_ctrl & pwdata[0] & (state == ST_IDLE);

   // first-level decode
   wire [1:0] l1_kind = mif.rdata[1:0];
   wire l1_is_table = (l1_kind == L1_COARSE) | (l1_kind == L1_FINE);
   wire [31:0] l1_addr = {table_base_register[31:14], modified_virtual_address[31:20], 2'b00};
   wire [31:0] section_phys = {mif.rdata[31:20], modified_virtual_address[19:0]};

   // second-level decode
   logic l2_fault;
   logic [2:0] l2_size;
   logic [31:0] l2_phys;
   logic [7:0] l2_perm;
   ptw_l2_decode u_dec (
      .i_desc(mif.rdata),
      .i_from_fine(l1_desc[1:0] == L1_FINE),
      .i_mva(modified_virtual_address),
      .o_fault(l2_fault),
      .o_size(l2_size),
      .o_phys(l2_phys),
      .o_perm(l2_perm)
   );

   wire go = (i_walk_start | sw_go) & (state == ST_IDLE);
   wire [31:0] go_mva = i_walk_start ? i_modified_virtual_address : modified_virtual_address;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (go) begin
               next_state = ST_L1_REQ;
            end
         end
         ST_L1_REQ: next_state = ST_L1_WAIT;
         ST_L1_WAIT: begin
            if (mif.ack) begin
               // tables walk on; sections and faults finish here
               next_state = l1_is_table ? ST_L2_REQ : ST_DONE;
            end
         end
         ST_L2_REQ: next_state = ST_L2_WAIT;
         ST_L2_WAIT: begin
            if (mif.ack) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // memory request held through the wait states only
   assign mif.req = (state == ST_L1_WAIT) | (state == ST_L2_WAIT);
   assign mif.addr = (state == ST_L2_WAIT) ? l2_addr(l1_desc, modified_virtual_address) : l1_addr;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         table_base_register <= RST_WORD;
         modified_virtual_address <= RST_WORD;
      end else begin
         if (apb_wr & hit_base) begin
            table_base_register <= pwdata;
         end
         if (go) begin
            modified_virtual_address <= go_mva;
         end else if (apb_wr & hit_mva & (state == ST_IDLE)) begin
            modified_virtual_address <= pwdata;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         l1_desc <= RST_WORD;
         l2_desc <= RST_WORD;
         phys <= RST_WORD;
         size <= SZ_NONE;
         perm <= 8'h00;
         domain <= 4'h0;
         cb <= 2'h0;
         fault_code <= FLT_NONE;
      end else if (go) begin
         fault_code <= FLT_NONE;
         size <= SZ_NONE;
         phys <= RST_WORD;
      end else if ((state == ST_L1_WAIT) & mif.ack) begin
         l1_desc <= mif.rdata;
         if (l1_kind == L1_FAULT) begin
            fault_code <= FLT_SECTION_XLT;
         end else if (l1_kind == L1_SECTION) begin
            // permissions and policy are published with the address
            perm <= {4{mif.rdata[11:10]}};
            cb <= mif.rdata[3:2];
            phys <= section_phys;
            size <= SZ_SECTION;
            domain <= mif.rdata[8:5];
         end else begin
            domain <= mif.rdata[8:5];
         end
      end else if ((state == ST_L2_WAIT) & mif.ack) begin
         l2_desc <= mif.rdata;
         if (l2_fault) begin
            fault_code <= FLT_PAGE_XLT;
         end else begin
            phys <= l2_phys;
            size <= l2_size;
            perm <= l2_perm;
            cb <= mif.rdata[3:2];
         end
      end
   end

   assign done_pulse = (state == ST_DONE);
   assign o_walk_busy = (state != ST_IDLE);
   assign o_walk_done = done_pulse;
   assign o_walk_fault = done_pulse & (fault_code != FLT_NONE);
   assign o_fault_code = fault_code;
   assign o_phys_addr = phys;
   assign o_page_size = size;
   assign o_access_permission_field = perm;
   assign o_domain = domain;
   assign o_cachable = cb[1];
   assign o_bufferable = cb[0];

   // apb read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (apb_rd_sel) begin
         case (paddr)
            OFS_CTRL: prdata = {31'h0000_0000, o_walk_busy};
            OFS_TABLE_BASE: prdata = table_base_register;
            OFS_MVA: prdata = modified_virtual_address;
            OFS_STATUS: prdata = {21'h00_0000, size, fault_code, domain};
            OFS_PHYS: prdata = phys;
            OFS_ATTR: prdata = {22'h00_0000, cb, perm};
            OFS_L1_DESC: prdata = l1_desc;
            OFS_L2_DESC: prdata = l2_desc;
            default: prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/page_table_walk_decoder_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module page_table_walk_decoder_tb;
   import ptw_pkg::*;
   localparam logic [31:0] BS = 32'h0004_0000;
   localparam logic [31:0] VA = 32'h1234_5678;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, st = 0;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, modified_virtual_address = '0, prd, rd, pha, ma, md;
   logic rdy, serr, se, busy, done, flt, cc, bb, mr, ak;
   logic [3:0] fc, dom;
   logic [2:0] sz;
   logic [7:0] perm;
   int err_count = 0, tests_run = 0, cyc = 0;
   ptw_walker dut (.i_core_clk(clk), .i_sys_rst(rst), .psel(psel), .penable(pen), .pwrite(pwr),
      .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(rdy), .pslverr(serr), .i_walk_start(st),
      .i_modified_virtual_address(modified_virtual_address), .o_walk_busy(busy), .o_walk_done(done),
      .o_walk_fault(flt), .o_fault_code(fc), .o_phys_addr(pha), .o_page_size(sz),
      .o_access_permission_field(perm), .o_domain(dom), .o_cachable(cc), .o_bufferable(bb),
      .o_mem_req(mr), .o_mem_addr(ma), .i_mem_ack(ak), .i_mem_rdata(md));
   ptw_mem_model mm (.i_core_clk(clk), .i_req(mr), .i_addr(ma), .o_ack(ak), .o_rdata(md));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk) pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = prd;
      se = serr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic walk(input logic [31:0] d1, d2, input int rep, lat, pin,
         input logic [31:0] eph, input logic [3:0] efc, input logic [2:0] esz, input logic [7:0] ep);
      logic [31:0] a1, a2;
      int n;
      a1 = {BS[31:14], VA[31:20], 2'h0};
      a2 = d1[1] ? {d1[31:12], VA[19:10], 2'h0} : {d1[31:10], VA[19:12], 2'h0};
      mm.mem[a1] = d1;
      for (int i = 0; i < rep; i++) mm.mem[(a2 & ~(rep * 4 - 1)) + 4 * i] = d2;
      mm.lat = lat;
      mm.seen.delete();
      apb(1'b1, OFS_TABLE_BASE, BS);
      if (pin) begin
         modified_virtual_address <= VA;
         st <= 1'b1;
         @(posedge clk) st <= 1'b0;
      end else begin
         apb(1'b1, OFS_MVA, VA);
         apb(1'b1, OFS_CTRL, 32'h1);
      end
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(n < 200, 1'b1);
      chk(busy, 1'b1);
      chk({flt, fc, sz}, {efc != FLT_NONE, efc, esz});
      chk(mm.seen.size(), d1[0] ? 2 : 1);
      chk(mm.seen[0], a1);
      if (d1[0]) chk(mm.seen[1], a2);
      if (efc == FLT_NONE) begin
         chk(pha, eph);
         chk({perm, dom}, {ep, d1[8:5]});
         chk({cc, bb}, d1[0] ? d2[3:2] : d1[3:2]);
      end
      @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[10:4], {esz, efc});
   endtask
   task automatic t_regs;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, RST_WORD);
      apb(1'b0, 12'h020, 32'h0);
      chk(se, 1'b1);
   endtask
   // table descriptors keep bit 4 set and must-be-clear bits zero
   task automatic t_coarse;
      walk(32'h0008_00B1, 32'hABCD_0E4D, 16, 0, 0, 32'hABCD_5678, FLT_NONE, SZ_LARGE,
         8'hE4);
      walk(32'h0008_00B1, 32'hABCD_E1BA, 1, 3, 0, 32'hABCD_E678, FLT_NONE, SZ_SMALL, 8'h1B);
      walk(32'h0008_00B1, 32'h1357_90F7, 1, 0, 0, 32'h1357_9678, FLT_NONE, SZ_SMALL,
         8'h0F);
   endtask
   task automatic t_fine;
      walk(32'h000C_0153, 32'h2468_AC2B, 1, 0, 1, 32'h2468_AE78, FLT_NONE, SZ_TINY, 8'hAA);
      walk(32'h000C_0153, 32'hABCD_0E4D, 64, 2, 1, 32'hABCD_5678, FLT_NONE, SZ_LARGE, 8'hE4);
      walk(32'h000C_0153, 32'hABCD_E1BA, 4, 0, 1, 32'hABCD_E678, FLT_NONE, SZ_SMALL, 8'h1B);
   endtask
   task automatic t_fault;
      walk(32'h0008_00B0, 32'h0, 1, 0, 0, 32'h0, FLT_SECTION_XLT, SZ_NONE, 8'h0);
      walk(32'h0008_00B1, 32'hFFFF_FFFC, 1, 1, 0, 32'h0, FLT_PAGE_XLT, SZ_NONE, 8'h0);
   endtask
   task automatic t_section;
      walk(32'h8760_0C7A, 32'h0, 1, 0, 0, 32'h8764_5678, FLT_NONE, SZ_SECTION, 8'hFF);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_coarse();
      t_fine();
      t_fault();
      t_section();
      conclude();
   end
endmodule
`default_nettype wire

// ---- tb/ptw_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// system memory holding the tables; lat sets the answer delay
module ptw_mem_model (
   input wire logic i_core_clk,
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [int unsigned];
   logic [31:0] seen [$];
   int lat = 0;
   initial begin
      o_ack = 1'b0;
      o_rdata = 32'hA5A5_A5A5;
      forever begin
         @(posedge i_core_clk);
         if (i_req === 1'b1) begin
            seen.push_back(i_addr);
            repeat (lat) @(posedge i_core_clk);
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr];
            @(posedge i_core_clk);
            o_ack <= 1'b0;
            o_rdata <= ~mem[i_addr];
            while (i_req === 1'b1) @(posedge i_core_clk);
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/ptw_walker_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptw_walker_assertions
   import ptw_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic i_walk_start,
   input wire logic [31:0] i_modified_virtual_address,
   input wire logic o_walk_busy,
   input wire logic o_walk_done,
   input wire logic o_walk_fault,
   input wire logic [3:0] o_fault_code,
   input wire logic [31:0] o_phys_addr,
   input wire logic [2:0] o_page_size,
   input wire logic o_mem_req,
   input wire logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata
);
   logic [31:0] tb_q, mva_q, l1_q, l2_q;
   logic [1:0] nreq;
   logic req_d;
   wire logic wr = psel && penable && pwrite && pready;
   wire logic rose = o_mem_req && !req_d;
   wire logic got = o_mem_req && i_mem_ack;
   wire logic ok2 = o_walk_done && nreq == 2'h2 && !o_walk_fault;
   // nreq counts fetches of the current walk
   always_ff @(posedge i_core_clk) begin
      req_d <= i_sys_rst ? 1'b0 : o_mem_req;
      nreq <= (i_sys_rst || o_walk_done) ? 2'h0 : nreq + {1'b0, rose};
   end
   always_ff @(posedge i_core_clk) begin
      if (wr && paddr == OFS_TABLE_BASE) tb_q <= pwdata;
      if (wr && paddr == OFS_MVA && !o_walk_busy) mva_q <= pwdata;
      if (i_walk_start && !o_walk_busy) mva_q <= i_modified_virtual_address;
      if (got && nreq == 2'h1) l1_q <= i_mem_rdata;
      if (got && nreq == 2'h2) l2_q <= i_mem_rdata;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // first-level answer that is a fault or a section
   sequence s_l1_stop;
      got && nreq == 2'h1 && !i_mem_rdata[0];
   endsequence
   property p_l1_addr;
      rose && nreq == 2'h0 |-> o_mem_addr == {tb_q[31:14], mva_q[31:20], 2'h0};
   endproperty
   a_l1_addr: assert property (p_l1_addr) else $error("bad first-level address");
   property p_l2_coarse;
      rose && nreq == 2'h1 && l1_q[1:0] == L1_COARSE
         |-> o_mem_addr == {l1_q[31:10], mva_q[19:12], 2'h0};
   endproperty
   a_l2_coarse: assert property (p_l2_coarse) else $error("bad coarse address");
   property p_l2_fine;
      rose && nreq == 2'h1 && l1_q[1:0] == L1_FINE
         |-> o_mem_addr == {l1_q[31:12], mva_q[19:10], 2'h0};
   endproperty
   a_l2_fine: assert property (p_l2_fine) else $error("bad fine address");
   property p_stop;
      s_l1_stop |-> ##1 (!o_walk_done && !rose) ##1 (o_walk_done && !rose);
   endproperty
   a_stop: assert property (p_stop) else $error("no stop after first level");
   property p_l1_fault;
      o_walk_done && nreq == 2'h1 && l1_q[1:0] == L1_FAULT
         |-> o_walk_fault && o_fault_code == FLT_SECTION_XLT;
   endproperty
   a_l1_fault: assert property (p_l1_fault) else $error("no section fault");
   property p_l2_fault;
      o_walk_done && nreq == 2'h2 && l2_q[1:0] == L2_FAULT
         |-> o_walk_fault && o_fault_code == FLT_PAGE_XLT;
   endproperty
   a_l2_fault: assert property (p_l2_fault) else $error("no page fault");
   property p_size;
      ok2 |-> o_page_size == (l2_q[1:0] == L2_LARGE ? SZ_LARGE :
         (l2_q[1:0] == L2_TINY && l1_q[1:0] == L1_FINE) ? SZ_TINY : SZ_SMALL);
   endproperty
   a_size: assert property (p_size) else $error("bad page size");
   property p_phys;
      ok2 && l2_q[1:0] == L2_LARGE |-> o_phys_addr == {l2_q[31:16], mva_q[15:0]};
   endproperty
   a_phys: assert property (p_phys) else $error("bad large address");
endmodule
bind ptw_walker ptw_walker_assertions u_chk (.*);
`default_nettype wire
